// ==== logic/scc_params.svh ====
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

// Register byte addresses
`define SCC_CTRL_OFF 8'h00
`define SCC_PRESC_OFF 8'h04
`define SCC_PLLINC_OFF 8'h08
`define SCC_AUDINC_OFF 8'h0C
`define SCC_STAT_OFF 8'h10
`define SCC_IRQ_OFF 8'h14

// Control register fields
`define SCC_CTRL_SW_LSB 0
`define SCC_CTRL_EXT_EN 2
`define SCC_CTRL_CSS_EN 3
`define SCC_CTRL_PLL_EN 4
`define SCC_CTRL_PLL_SRC 5
`define SCC_CTRL_AUD_EN 6

// Prescaler register fields, three bits of log2 divide each
`define SCC_PRESC_AHB_LSB 0
`define SCC_PRESC_APB2_LSB 3
`define SCC_PRESC_APB1_LSB 6

// Interrupt register fields
`define SCC_IRQ_EXT_IE 0
`define SCC_IRQ_PLL_IE 1
`define SCC_IRQ_EXT_CLR 8
`define SCC_IRQ_PLL_CLR 9

// Status register fields
`define SCC_STAT_SRC_LSB 0
`define SCC_STAT_EXT_OK 2
`define SCC_STAT_LOCK 3
`define SCC_STAT_EXT_FAIL 4
`define SCC_STAT_PLL_FAIL 5

// Reset values
`define SCC_CTRL_RST 32'h0000_0000
`define SCC_PRESC_RST 9'h000
`define SCC_PLLINC_RST 16'h0000
`define SCC_AUDINC_RST 16'h0000

// Timing
`define SCC_MCLK_MHZ 100
`define SCC_EXT_MIN_MHZ 4
`define SCC_FAIL_TIME_NS 1000
`define SCC_FAIL_CYC ((`SCC_FAIL_TIME_NS * `SCC_MCLK_MHZ) / 1000)
`define SCC_LOCK_TIME_NS 2000
`define SCC_LOCK_CYC ((`SCC_LOCK_TIME_NS * `SCC_MCLK_MHZ) / 1000)

// Frequency ceilings as oscillator increments (f = inc * mclk / 65536)
`define SCC_PLL_MAX_MHZ 84
`define SCC_APB1_MAX_MHZ 42
`define SCC_PLL_INC_MAX ((`SCC_PLL_MAX_MHZ * 65536) / `SCC_MCLK_MHZ)
`define SCC_APB1_INC_MAX ((`SCC_APB1_MAX_MHZ * 65536) / `SCC_MCLK_MHZ)

`endif

// ==== logic/scc_pkg.sv ====
package scc_pkg;

   typedef enum logic [1:0] {SCC_SRC_RC, SCC_SRC_EXT, SCC_SRC_PLL} scc_src_e;

   typedef enum logic [1:0] {SCC_SW_RUN, SCC_SW_OLD, SCC_SW_NEW} scc_sw_e;

   typedef struct packed {
      logic rc_s1;
      logic rc_s2;
      logic rc_s3;
      logic ex_s1;
      logic ex_s2;
      logic ex_s3;
      scc_src_e sw_sel;
      logic ext_en;
      logic css_en;
      logic pll_en;
      logic pll_src;
      logic aud_en;
      logic [2:0][2:0] presc;
      logic [15:0] pll_inc;
      logic [15:0] aud_inc;
      logic ext_ie;
      logic pll_ie;
      logic ext_fail;
      logic pll_fail;
      scc_src_e active;
      scc_src_e target;
      scc_sw_e sw;
      logic [7:0] ext_wd;
      logic [7:0] lock_cnt;
      logic pll_lock;
      logic [15:0] pll_acc;
      logic [15:0] aud_acc;
      logic [2:0][7:0] pre_cnt;
      logic sys_tick;
      logic [2:0] dom_tick;
      logic aud_tick;
      logic [31:0] rdata;
   } scc_state_s;

endpackage : scc_pkg

// ==== logic/scc_clock_ctrl.sv ====
`timescale 1ns/10ps
`include "scc_params.svh"

// Functional notes
// - Every reset leaves the system clock on the 16 MHz internal RC oscillator.
// - Software selects the RC oscillator or the 4-26 MHz external source.
// - A watched external source that stops makes hardware fall back to RC.
// - An external failure raises an interrupt only if software enabled it.
// - The chosen oscillator feeds a main PLL capped at 84 MHz.
// - Loss of the PLL input is flagged and can interrupt software.
// - Separate prescalers derive the AHB, fast APB and slow APB clocks.
// - AHB and fast APB clocks stay at or below 84 MHz.
// - The slow APB clock never exceeds 42 MHz, dividing a PLL above that by two at least.
// - An audio PLL produces the audio master clock for 8-192 kHz rates.
module scc_clock_ctrl
#(
   parameter int LOCK_CYC = `SCC_LOCK_CYC
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Oscillator pins
   input wire logic rc_osc_in,
   input wire logic ext_osc_in,
   // Clock outputs as one-cycle ticks of mclk
   output logic sys_tick,
   output logic ahb_tick,
   output logic apb2_tick,
   output logic apb1_tick,
   output logic audio_mclk_tick,
   // Status
   output scc_pkg::scc_src_e sys_src,
   output logic ext_fail_irq,
   output logic pll_fail_irq
);
   import scc_pkg::*;

   // The lock counter is eight bits wide
   if (LOCK_CYC < 1 || LOCK_CYC > 255)
   begin : g_bad_lock
      $error("LOCK_CYC must lie in 1..255");
   end

   scc_state_s q;
   scc_state_s d;

   always_comb
   begin
      logic rc_tk;
      logic ex_tk;
      logic pll_tk;
      logic ext_ok;
      logic pll_in_ok;
      logic ext_fail_ev;
      logic pll_fail_ev;
      logic old_tk;
      logic new_tk;
      logic tgt_ready;
      logic [16:0] sum;
      logic [15:0] inc;
      logic [2:0] lg;
      logic [7:0] div;
      rc_tk = 1'b0;
      ex_tk = 1'b0;
      pll_tk = 1'b0;
      ext_ok = 1'b0;
      pll_in_ok = 1'b0;
      ext_fail_ev = 1'b0;
      pll_fail_ev = 1'b0;
      old_tk = 1'b0;
      new_tk = 1'b0;
      tgt_ready = 1'b0;
      sum = 17'h0_0000;
      inc = 16'h0000;
      lg = 3'h0;
      div = 8'h00;
      d = q;

      // Pin synchronisers; edges are taken from the second stage on
      d.rc_s1 = rc_osc_in;
      d.rc_s2 = q.rc_s1;
      d.rc_s3 = q.rc_s2;
      d.ex_s1 = ext_osc_in;
      d.ex_s2 = q.ex_s1;
      d.ex_s3 = q.ex_s2;
      rc_tk = q.rc_s2 & ~q.rc_s3;
      ex_tk = q.ex_s2 & ~q.ex_s3;

      // Watchdog on the external source: no edge for longer than a few
      // periods of the slowest allowed crystal means it has stopped
      if (!q.ext_en || ex_tk)
         d.ext_wd = 8'h00;
      else if (q.ext_wd != 8'(`SCC_FAIL_CYC))
         d.ext_wd = q.ext_wd + 8'h01;
      ext_ok = q.ext_en && (q.ext_wd != 8'(`SCC_FAIL_CYC));
      ext_fail_ev = q.ext_en && q.css_en &&
         (q.ext_wd == 8'(`SCC_FAIL_CYC - 1)) && !ex_tk;

      // Main PLL, modelled as a phase accumulator once locked
      pll_in_ok = q.pll_src ? ext_ok : 1'b1;
      pll_fail_ev = q.pll_en && q.pll_lock && !pll_in_ok;
      if (!q.pll_en || !pll_in_ok)
      begin
         d.lock_cnt = 8'h00;
         d.pll_lock = 1'b0;
         d.pll_acc = 16'h0000;
      end
      else if (!q.pll_lock)
      begin
         d.lock_cnt = q.lock_cnt + 8'h01;
         d.pll_lock = (q.lock_cnt == 8'(LOCK_CYC - 1));
      end
      else
      begin
         inc = (q.pll_inc > 16'(`SCC_PLL_INC_MAX)) ?
            16'(`SCC_PLL_INC_MAX) : q.pll_inc;
         sum = {1'b0, q.pll_acc} + {1'b0, inc};
         d.pll_acc = sum[15:0];
         pll_tk = sum[16];
      end

      // Audio PLL runs from the main PLL's reference once that is locked
      if (!q.aud_en || !q.pll_lock)
      begin
         d.aud_acc = 16'h0000;
         d.aud_tick = 1'b0;
      end
      else
      begin
         sum = {1'b0, q.aud_acc} + {1'b0, q.aud_inc};
         d.aud_acc = sum[15:0];
         d.aud_tick = sum[16];
      end

      // Source switch: the old clock's next edge closes its last whole
      // period and is swallowed, then the output waits for a fresh edge of
      // the new one, so a phase can only be stretched, never cut short
      unique case (q.active)
         SCC_SRC_RC: old_tk = rc_tk;
         SCC_SRC_EXT: old_tk = ex_tk;
         SCC_SRC_PLL: old_tk = pll_tk;
         default: old_tk = 1'b0;
      endcase
      unique case (q.target)
         SCC_SRC_RC: new_tk = rc_tk;
         SCC_SRC_EXT: new_tk = ex_tk;
         SCC_SRC_PLL: new_tk = pll_tk;
         default: new_tk = 1'b0;
      endcase
      unique case (q.sw_sel)
         SCC_SRC_RC: tgt_ready = 1'b1;
         SCC_SRC_EXT: tgt_ready = ext_ok;
         SCC_SRC_PLL: tgt_ready = q.pll_lock;
         default: tgt_ready = 1'b0;
      endcase
      d.sys_tick = 1'b0;
      unique case (q.sw)
         SCC_SW_RUN:
         begin
            d.sys_tick = old_tk;
            if (q.sw_sel != q.active && tgt_ready)
            begin
               d.target = q.sw_sel;
               d.sw = SCC_SW_OLD;
            end
         end
         SCC_SW_OLD:
         begin
            if (old_tk)
               d.sw = SCC_SW_NEW;
         end
         SCC_SW_NEW:
         begin
            d.sys_tick = new_tk;
            if (new_tk)
            begin
               d.active = q.target;
               d.sw = SCC_SW_RUN;
            end
         end
      endcase
      // A dead external source would never finish a switch in flight, so
      // the fallback overrides any state of the switch
      if (ext_fail_ev && (q.active == SCC_SRC_EXT ||
         q.target == SCC_SRC_EXT || (q.pll_src &&
         (q.active == SCC_SRC_PLL || q.target == SCC_SRC_PLL))))
      begin
         d.target = SCC_SRC_RC;
         d.sw = SCC_SW_NEW;
      end

      // Prescalers, all counting system clock ticks
      for (int i = 0; i < 3; i++)
      begin
         lg = q.presc[i];
         if (i == 2 && lg == 3'h0 && q.active == SCC_SRC_PLL &&
            q.pll_inc > 16'(`SCC_APB1_INC_MAX))
            lg = 3'h1;
         div = 8'h01 << lg;
         d.dom_tick[i] = 1'b0;
         if (q.sys_tick)
         begin
            if (q.pre_cnt[i] >= div - 8'h01)
            begin
               d.pre_cnt[i] = 8'h00;
               d.dom_tick[i] = 1'b1;
            end
            else
               d.pre_cnt[i] = q.pre_cnt[i] + 8'h01;
         end
      end

      // Register writes
      if (wr)
      begin
         unique case (addr)
            `SCC_CTRL_OFF:
            begin
               d.sw_sel = (wdata[`SCC_CTRL_SW_LSB +: 2] == 2'h3) ?
                  q.sw_sel : scc_src_e'(wdata[`SCC_CTRL_SW_LSB +: 2]);
               d.ext_en = wdata[`SCC_CTRL_EXT_EN];
               d.css_en = wdata[`SCC_CTRL_CSS_EN];
               d.pll_en = wdata[`SCC_CTRL_PLL_EN];
               d.pll_src = wdata[`SCC_CTRL_PLL_SRC];
               d.aud_en = wdata[`SCC_CTRL_AUD_EN];
            end
            `SCC_PRESC_OFF:
            begin
               d.presc[0] = wdata[`SCC_PRESC_AHB_LSB +: 3];
               d.presc[1] = wdata[`SCC_PRESC_APB2_LSB +: 3];
               d.presc[2] = wdata[`SCC_PRESC_APB1_LSB +: 3];
            end
            `SCC_PLLINC_OFF: d.pll_inc = wdata[15:0];
            `SCC_AUDINC_OFF: d.aud_inc = wdata[15:0];
            `SCC_IRQ_OFF:
            begin
               d.ext_ie = wdata[`SCC_IRQ_EXT_IE];
               d.pll_ie = wdata[`SCC_IRQ_PLL_IE];
               d.ext_fail = q.ext_fail & ~wdata[`SCC_IRQ_EXT_CLR];
               d.pll_fail = q.pll_fail & ~wdata[`SCC_IRQ_PLL_CLR];
            end
            default: ;
         endcase
      end

      // Failure handling; a new event beats a clear in the same cycle
      if (ext_fail_ev)
      begin
         d.ext_fail = 1'b1;
         if (q.sw_sel == SCC_SRC_EXT ||
            (q.sw_sel == SCC_SRC_PLL && q.pll_src))
            d.sw_sel = SCC_SRC_RC;
      end
      if (pll_fail_ev)
         d.pll_fail = 1'b1;

      // Register reads, answered in the next cycle
      d.rdata = 32'h0000_0000;
      if (rd)
      begin
         unique case (addr)
            `SCC_CTRL_OFF:
            begin
               d.rdata[`SCC_CTRL_SW_LSB +: 2] = q.sw_sel;
               d.rdata[`SCC_CTRL_EXT_EN] = q.ext_en;
               d.rdata[`SCC_CTRL_CSS_EN] = q.css_en;
               d.rdata[`SCC_CTRL_PLL_EN] = q.pll_en;
               d.rdata[`SCC_CTRL_PLL_SRC] = q.pll_src;
               d.rdata[`SCC_CTRL_AUD_EN] = q.aud_en;
            end
            `SCC_PRESC_OFF: d.rdata[8:0] = q.presc;
            `SCC_PLLINC_OFF: d.rdata[15:0] = q.pll_inc;
            `SCC_AUDINC_OFF: d.rdata[15:0] = q.aud_inc;
            `SCC_STAT_OFF:
            begin
               d.rdata[`SCC_STAT_SRC_LSB +: 2] = q.active;
               d.rdata[`SCC_STAT_EXT_OK] = ext_ok;
               d.rdata[`SCC_STAT_LOCK] = q.pll_lock;
               d.rdata[`SCC_STAT_EXT_FAIL] = q.ext_fail;
               d.rdata[`SCC_STAT_PLL_FAIL] = q.pll_fail;
            end
            `SCC_IRQ_OFF:
            begin
               d.rdata[`SCC_IRQ_EXT_IE] = q.ext_ie;
               d.rdata[`SCC_IRQ_PLL_IE] = q.pll_ie;
            end
            default: d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.sw_sel <= SCC_SRC_RC;
         q.active <= SCC_SRC_RC;
         q.target <= SCC_SRC_RC;
         q.sw <= SCC_SW_RUN;
         q.presc <= `SCC_PRESC_RST;
         q.pll_inc <= `SCC_PLLINC_RST;
         q.aud_inc <= `SCC_AUDINC_RST;
      end
      else
         q <= d;
   end

   assign rdata = q.rdata;
   assign sys_tick = q.sys_tick;
   assign ahb_tick = q.dom_tick[0];
   assign apb2_tick = q.dom_tick[1];
   assign apb1_tick = q.dom_tick[2];
   assign audio_mclk_tick = q.aud_tick;
   assign sys_src = q.active;
   assign ext_fail_irq = q.ext_fail & q.ext_ie;
   assign pll_fail_irq = q.pll_fail & q.pll_ie;

endmodule : scc_clock_ctrl

// ==== verification/scc_clock_ctrl_asserts.sv ====
`timescale 1ns/10ps
`include "scc_params.svh"
module scc_clock_ctrl_asserts
#(
   parameter int LOCK_CYC = `SCC_LOCK_CYC
)
(
   // Clock, reset and register port
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   // Clocks and status
   input wire logic sys_tick,
   input wire logic apb1_tick,
   input scc_pkg::scc_src_e sys_src,
   input wire logic ext_fail_irq,
   input wire logic pll_fail_irq
);
   import scc_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   reset_rc_a: assert property (!$past(rst_n) |-> sys_src == SCC_SRC_RC)
      else $error("source not RC after reset");
   src_code_a: assert property (sys_src != 2'h3)
      else $error("illegal source code");
   read_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data outside read slot");
   status_src_a: assert property ($past(rd) && $past(addr) == 8'h10
      |-> rdata[1:0] == $past(sys_src))
      else $error("status source mismatch");
   fail_fallback_a: assert property ($rose(ext_fail_irq) && !$past(wr)
      |-> ##[0:20] sys_src == SCC_SRC_RC)
      else $error("no fallback to RC");
   ext_irq_hold_a: assert property (ext_fail_irq
      && !(wr && addr == `SCC_IRQ_OFF) |=> ext_fail_irq)
      else $error("ext irq dropped");
   pll_irq_hold_a: assert property (pll_fail_irq
      && !(wr && addr == `SCC_IRQ_OFF) |=> pll_fail_irq)
      else $error("pll irq dropped");
   apb1_gap_a: assert property (apb1_tick |=> !apb1_tick)
      else $error("slow domain above half rate");
   rc_gap_a: assert property (sys_tick && sys_src == SCC_SRC_RC
      |=> !sys_tick)
      else $error("short RC clock phase");
   cover property (sys_src == SCC_SRC_PLL);
   cover property ($rose(ext_fail_irq));
   cover property ($rose(pll_fail_irq));
endmodule : scc_clock_ctrl_asserts

bind scc_clock_ctrl scc_clock_ctrl_asserts #(.LOCK_CYC(LOCK_CYC)) chk (
   .mclk, .rst_n, .addr, .wr, .rd, .rdata, .sys_tick, .apb1_tick,
   .sys_src, .ext_fail_irq, .pll_fail_irq);

// ==== verification/scc_clock_ctrl_bench.sv ====
`timescale 1ns/10ps
`include "scc_params.svh"
module scc_clock_ctrl_bench;
   import scc_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rc_osc_in = 1'b0;
   logic ext_osc_in = 1'b0;
   logic ext_run = 1'b0;
   logic [1:0] rc_cnt = 2'h0;
   logic [1:0] ex_cnt = 2'h0;
   logic [31:0] rdata, v;
   logic [31:0] seed = 32'hC894B86E;
   logic [4:0] tk;
   scc_src_e sys_src;
   logic ext_irq, pll_irq;
   int cnt [5] = '{0, 0, 0, 0, 0};
   int base [5];
   int got [5];
   int num_errors = 0;
   int samples_checked = 0;
   int cyc = 0;

   scc_clock_ctrl #(.LOCK_CYC(4)) dut (
      .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .rc_osc_in(rc_osc_in),
      .ext_osc_in(ext_osc_in), .sys_tick(tk[0]), .ahb_tick(tk[1]),
      .apb2_tick(tk[2]), .apb1_tick(tk[3]), .audio_mclk_tick(tk[4]),
      .sys_src(sys_src), .ext_fail_irq(ext_irq), .pll_fail_irq(pll_irq));

   always #5 mclk = ~mclk;

   // RC pin period 6 cycles, external pin period 8 cycles while running
   always @(posedge mclk)
   begin
      rc_cnt <= (rc_cnt == 2'h2) ? 2'h0 : rc_cnt + 2'h1;
      if (rc_cnt == 2'h2)
         rc_osc_in <= ~rc_osc_in;
      ex_cnt <= ex_cnt + 2'h1;
      if (ext_run && ex_cnt == 2'h3)
         ext_osc_in <= ~ext_osc_in;
      foreach (cnt[i])
         cnt[i] <= cnt[i] + int'(tk[i]);
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         num_errors++;
         summarize();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic near(input int a, input int b);
      return (a - b <= 1) && (b - a <= 1);
   endfunction : near

   task automatic check(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   task automatic count(input int n);
      @(posedge mclk);
      #1;
      base = cnt;
      repeat (n) @(posedge mclk);
      #1;
      foreach (got[i])
         got[i] = cnt[i] - base[i];
   endtask : count

   task automatic wait_src(input scc_src_e t);
      for (int i = 0; i < 400 && sys_src !== t; i++)
         @(posedge mclk);
      #1;
   endtask : wait_src

   task automatic wait_irq(input logic pll);
      for (int i = 0; i < 400 && (pll ? pll_irq : ext_irq) !== 1'b1; i++)
         @(posedge mclk);
      #1;
   endtask : wait_irq

   task automatic summarize;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize

   initial
   begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      #1;
      check("src", sys_src, SCC_SRC_RC);
      for (int a = 0; a < 32; a += 4)
      begin
         rd_reg(a[7:0], v);
         check("reset reg", v, 32'h0);
      end
      // Random fills, masked to the implemented field widths
      for (int i = 0; i < 9; i++)
      begin
         seed = lfsr(seed);
         wr_reg(8'h04 + 8'(4 * (i % 3)), seed);
         rd_reg(8'h04 + 8'(4 * (i % 3)), v);
         check("readback", v, seed & (i % 3 ? 32'hFFFF : 32'h1FF));
      end
      wr_reg(`SCC_PRESC_OFF, 32'h0D1);
      count(240);
      check("rc rate", near(got[0], 40), 1'b1);
      for (int i = 1; i < 4; i++)
         check("domain rate", near(got[i], got[0] >> i), 1'b1);
      ext_run <= 1'b1;
      wr_reg(`SCC_CTRL_OFF, 32'h0D);
      wait_src(SCC_SRC_EXT);
      check("ext src", sys_src, SCC_SRC_EXT);
      count(240);
      check("ext rate", near(got[0], 30), 1'b1);
      wr_reg(`SCC_IRQ_OFF, 32'h1);
      ext_run <= 1'b0;
      wait_irq(1'b0);
      check("ext irq", ext_irq, 1'b1);
      wait_src(SCC_SRC_RC);
      check("fallback", sys_src, SCC_SRC_RC);
      rd_reg(`SCC_STAT_OFF, v);
      check("fail flag", v[4], 1'b1);
      wr_reg(`SCC_IRQ_OFF, 32'h101);
      check("irq clear", ext_irq, 1'b0);
      wr_reg(`SCC_IRQ_OFF, 32'h0);
      ext_run <= 1'b1;
      wr_reg(`SCC_CTRL_OFF, 32'h0D);
      wait_src(SCC_SRC_EXT);
      ext_run <= 1'b0;
      repeat (200) @(posedge mclk);
      #1;
      check("masked irq", ext_irq, 1'b0);
      rd_reg(`SCC_STAT_OFF, v);
      check("masked flag", v[4], 1'b1);
      check("fallback", sys_src, SCC_SRC_RC);
      wr_reg(`SCC_IRQ_OFF, 32'h100);
      ext_run <= 1'b1;
      wr_reg(`SCC_PRESC_OFF, 32'h0);
      wr_reg(`SCC_PLLINC_OFF, 32'hFFFF);
      wr_reg(`SCC_AUDINC_OFF, 32'h4000);
      wr_reg(`SCC_CTRL_OFF, 32'h76);
      wait_src(SCC_SRC_PLL);
      check("pll src", sys_src, SCC_SRC_PLL);
      count(200);
      check("pll cap", near(got[0], 168), 1'b1);
      check("slow rate", near(got[3], got[0] >> 1), 1'b1);
      check("audio rate", near(got[4], 50), 1'b1);
      wr_reg(`SCC_IRQ_OFF, 32'h2);
      ext_run <= 1'b0;
      wait_irq(1'b1);
      check("pll irq", pll_irq, 1'b1);
      rd_reg(`SCC_STAT_OFF, v);
      check("pll flags", v[5:3], 3'b100);
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      #1;
      check("src", sys_src, SCC_SRC_RC);
      rd_reg(`SCC_CTRL_OFF, v);
      check("ctrl", v, 32'h0);
      summarize();
   end
endmodule : scc_clock_ctrl_bench
